// ===== rtl/sbs_sram_ctrl.v
// Synchronous burst SRAM core with burst ordering, read timing choice and sleep
`timescale 1ns/10ps
`include "sbs_map.vh"
////////////////////////////////////////////////////////////////////////////////
module sbs_sram_ctrl #(
    parameter AW    = 8,
    parameter DW    = 16,
    parameter RECW  = 8
) (
    // Clock and reset
    input  wire          mclk,
    input  wire          reset_n,
    // Wishbone slave
    input  wire          wb_cyc_i,
    input  wire          wb_stb_i,
    input  wire          wb_we_i,
    input  wire [3:0]    wb_adr_i,
    input  wire [3:0]    wb_sel_i,
    input  wire [31:0]   wb_dat_i,
    output reg  [31:0]   wb_dat_o,
    output reg           wb_ack_o,
    // SRAM command port
    input  wire          sramSelect,
    input  wire          writeEnable,
    input  wire          addressAdvance,
    input  wire [AW-1:0] sramAddr,
    input  wire [DW-1:0] sramDataIn,
    input  wire          sleepRequest,
    // SRAM data out (two signals of the two-way bus) and write-refused flag
    output reg  [DW-1:0] sramDataOut,
    output reg           sramDataOe,
    output reg           writeRefused
);
    localparam RECOV_CYC = (`SBS_RECOVERY_NS + `SBS_CLK_PERIOD_NS - 1) / `SBS_CLK_PERIOD_NS;
    localparam ST_AWAKE = 2'h0;
    localparam ST_ENTER = 2'h1;
    localparam ST_SLEEP = 2'h2;
    localparam ST_RECOV = 2'h3;

    reg  [DW-1:0]   mem_reg [0:(1<<AW)-1];
    reg  [1:0]      ctrl_reg;
    reg  [RECW-1:0] recovLimit_reg;
    reg  [RECW-1:0] recovCnt_reg;
    reg  [1:0]      state_reg;
    reg  [1:0]      state_next;
    reg  [1:0]      entryCnt_reg;
    reg             burstActive_reg;
    reg  [DW-1:0]   pipeData_reg;
    reg             pipeValid_reg;
    reg             wrBlocked_reg;
    wire            sleepSync;
    wire [AW-1:0]   burstAddr;
    wire            asleep;
    wire            active;
    wire            loadStrobe;
    wire            advStrobe;
    wire [AW-1:0]   accAddr;
    wire            doRead;
    wire            doWrite;
    wire            wbHit;
    reg             writeMode_reg;
    wire            cmdWrite;
    wire            cmdValid;

    ////////////////////////////////////////////////////////////////////////////
    // Sleep request synchronisation and sleep state machine
    sbs_sync2 u_sync (
        .mclk    (mclk),
        .reset_n (reset_n),
        .asyncIn (sleepRequest),
        .syncOut (sleepSync)
    );

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_AWAKE: begin
                if (sleepSync)
                    state_next = ST_ENTER;
            end
            ST_ENTER: begin
                if (!sleepSync)
                    state_next = ST_AWAKE;
                else if (entryCnt_reg == `SBS_SLEEP_ENTRY_CYC - 2'h1)
                    state_next = ST_SLEEP; // Two cycles in ST_ENTER, three after the synchronised request rises
            end
            ST_SLEEP: begin
                if (!sleepSync)
                    state_next = ST_RECOV; // Stays asleep while request is high
            end
            ST_RECOV: begin
                if (sleepSync)
                    state_next = ST_ENTER;
                else if (recovCnt_reg >= recovLimit_reg)
                    state_next = ST_AWAKE;
            end
            default: begin
                state_next = ST_AWAKE;
            end
        endcase
    end

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg    <= ST_AWAKE;
            entryCnt_reg <= 2'h0;
            recovCnt_reg <= {RECW{1'b0}};
        end else begin
            state_reg    <= state_next;
            entryCnt_reg <= (state_reg == ST_ENTER) ? entryCnt_reg + 2'h1 : 2'h0;
            recovCnt_reg <= (state_reg == ST_RECOV) ? recovCnt_reg + {{(RECW-1){1'b0}}, 1'b1} : {{(RECW-1){1'b0}}, 1'b1};
        end
    end

    assign asleep = (state_reg == ST_SLEEP);

    ////////////////////////////////////////////////////////////////////////////
    // Command decode and burst address
    assign active     = !asleep; // All command pins ignored while asleep
    assign loadStrobe = active && !addressAdvance && sramSelect;
    assign advStrobe  = active && addressAdvance && burstActive_reg;

    sbs_burst_addr #(
        .AW (AW)
    ) u_burst (
        .mclk          (mclk),
        .reset_n       (reset_n),
        .loadStrobe    (loadStrobe),
        .advanceStrobe (advStrobe),
        .interleaved   (ctrl_reg[`SBS_CTRL_BOS_BIT]),
        .startAddr     (sramAddr),
        .burstAddr     (burstAddr)
    );

    // Load cycles use the pin address, continue cycles the counter's next slot
    assign accAddr  = loadStrobe ? sramAddr : burstAddr;
    assign cmdWrite = loadStrobe ? writeEnable : writeMode_reg;
    assign cmdValid = loadStrobe || advStrobe;

    // Writes in recovery are refused to protect array contents
    assign doWrite = cmdValid && cmdWrite && (state_reg != ST_RECOV) && (state_reg != ST_ENTER);
    assign doRead  = cmdValid && !cmdWrite;

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            burstActive_reg <= 1'b0;
            writeMode_reg   <= 1'b0;
            wrBlocked_reg   <= 1'b0;
        end else if (active) begin
            if (loadStrobe) begin
                burstActive_reg <= 1'b1;
                writeMode_reg   <= writeEnable;
            end else if (!addressAdvance) begin
                burstActive_reg <= 1'b0;
            end
            if (cmdValid && cmdWrite && !doWrite)
                wrBlocked_reg <= 1'b1;
            else if (wbHit && wb_we_i && wb_adr_i == `SBS_WB_OFS_STAT)
                wrBlocked_reg <= 1'b0;
        end
    end

    // Array contents held across sleep: no reset, no write while asleep
    always @(posedge mclk) begin
        if (doWrite)
            mem_reg[accAddr] <= sramDataIn;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data path: flow-through or registered
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pipeData_reg  <= {DW{1'b0}};
            pipeValid_reg <= 1'b0;
            sramDataOut   <= {DW{1'b0}};
            sramDataOe    <= 1'b0;
            writeRefused  <= 1'b0;
        end else begin
            pipeData_reg  <= mem_reg[accAddr];
            pipeValid_reg <= doRead;
            writeRefused  <= wrBlocked_reg;
            if (state_next == ST_SLEEP || asleep) begin
                sramDataOe  <= 1'b0; // Outputs float while asleep
            end else if (ctrl_reg[`SBS_CTRL_ORS_BIT]) begin
                sramDataOut <= pipeData_reg; // Registered: one edge later
                sramDataOe  <= pipeValid_reg;
            end else begin
                sramDataOut <= mem_reg[accAddr]; // Flow-through: loaded on the edge that samples the command
                sramDataOe  <= doRead;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wishbone register slave, one registered ack per access, the cycle after the strobe
    assign wbHit = wb_cyc_i && wb_stb_i && !wb_ack_o;

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_reg       <= `SBS_CTRL_RESET;
            recovLimit_reg <= RECOV_CYC[RECW-1:0];
            wb_ack_o       <= 1'b0;
            wb_dat_o       <= 32'h00000000;
        end else begin
            wb_ack_o <= wbHit;
            wb_dat_o <= 32'h00000000;
            if (wbHit && wb_we_i && wb_sel_i[0]) begin
                case (wb_adr_i)
                    `SBS_WB_OFS_CTRL:  ctrl_reg <= wb_dat_i[1:0];
                    `SBS_WB_OFS_RECOV: recovLimit_reg <= wb_dat_i[RECW-1:0];
                    default:           ctrl_reg <= ctrl_reg;
                endcase
            end
            if (wbHit && !wb_we_i) begin
                case (wb_adr_i)
                    `SBS_WB_OFS_CTRL:  wb_dat_o <= {30'h0, ctrl_reg};
                    `SBS_WB_OFS_STAT:  wb_dat_o <= {29'h0, wrBlocked_reg,
                                                    state_reg == ST_RECOV, asleep};
                    `SBS_WB_OFS_RECOV: wb_dat_o <= {{(32-RECW){1'b0}}, recovLimit_reg};
                    default:           wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end
endmodule

// ===== rtl/sbs_map.vh
// Constants for the burst SRAM sleep and burst-order block
`ifndef SBS_MAP_VH
`define SBS_MAP_VH
`define SBS_BURST_LEN        3'h4
`define SBS_BURST_LAST       2'h3
`define SBS_BURST_NEXT       2'h1
`define SBS_SLEEP_ENTRY_CYC  2'h2
`define SBS_RECOVERY_NS      20
`define SBS_CLK_PERIOD_NS    25
`define SBS_WB_OFS_CTRL      4'h0
`define SBS_WB_OFS_STAT      4'h4
`define SBS_WB_OFS_RECOV     4'h8
`define SBS_CTRL_ORS_BIT     0
`define SBS_CTRL_BOS_BIT     1
`define SBS_STAT_SLEEP_BIT   0
`define SBS_STAT_RECOV_BIT   1
`define SBS_STAT_WBLK_BIT    2
`define SBS_CTRL_RESET       2'h1
`endif

// ===== rtl/sbs_burst_addr.v
// Burst address generator with linear and interleaved order
`timescale 1ns/10ps
`include "sbs_map.vh"
module sbs_burst_addr #(
    parameter AW = 16
) (
    // Clock and reset
    input  wire          mclk,
    input  wire          reset_n,
    // Control
    input  wire          loadStrobe,
    input  wire          advanceStrobe,
    input  wire          interleaved,
    input  wire [AW-1:0] startAddr,
    // Result
    output wire [AW-1:0] burstAddr
);
    reg [AW-1:0] base_reg;
    reg [1:0]    count_reg;
    wire [1:0]   lowBits;

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            base_reg  <= {AW{1'b0}};
            count_reg <= 2'h0;
        end else if (loadStrobe) begin
            base_reg  <= startAddr;
            count_reg <= `SBS_BURST_NEXT; // Load cycle used the pin address, first continue takes slot one
        end else if (advanceStrobe) begin
            count_reg <= count_reg + 2'h1; // Wraps to loaded address on the 5th clock
        end
    end

    // XOR for interleaved, add for linear
    assign lowBits   = interleaved ? (base_reg[1:0] ^ count_reg) : (base_reg[1:0] + count_reg);
    assign burstAddr = {base_reg[AW-1:2], lowBits};
endmodule

// ===== rtl/sbs_sync2.v
// Two-flop synchroniser for a level
`timescale 1ns/10ps
module sbs_sync2 (
    // Clock and reset
    input  wire mclk,
    input  wire reset_n,
    // Data
    input  wire asyncIn,
    output wire syncOut
);
    reg stage1_reg;
    reg stage2_reg;

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
        end else begin
            stage1_reg <= asyncIn;
            stage2_reg <= stage1_reg;
        end
    end

    assign syncOut = stage2_reg;
endmodule

// ===== test/sbs_sram_ctrl_props.sv
// Checker on the SRAM core ports
`timescale 1ns/10ps
module sbs_sram_ctrl_props (
    // Clock, reset and bus
    input wire        mclk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
    input wire [3:0]  wb_adr_i, wb_sel_i,
    input wire [31:0] wb_dat_i,
    // SRAM pins
    input wire        sramSelect, writeEnable, addressAdvance, sleepRequest, sramDataOe, writeRefused
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    reg       mode_reg;
    reg [7:0] quiet_reg;
    wire      busReq = wb_cyc_i && wb_stb_i;
    wire      rdLoad = sramSelect && !writeEnable && !addressAdvance && quiet_reg == 8'h40;
    // Track read timing choice and how long sleep has been released
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mode_reg <= 1'b1;
            quiet_reg <= 8'h40;
        end else begin
            if (busReq && wb_ack_o && wb_we_i && wb_adr_i == 4'h0 && wb_sel_i[0])
                mode_reg <= wb_dat_i[0];
            quiet_reg <= sleepRequest ? 8'h00 : quiet_reg + {7'h00, quiet_reg != 8'h40};
        end
    end
    a_ack_next: assert property (busReq && !wb_ack_o |=> wb_ack_o) else $error("ack missing");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_ack_idle: assert property (!busReq |=> !wb_ack_o) else $error("ack without request");
    a_sleep_float: assert property (sleepRequest [*8] |-> !sramDataOe)
        else $error("data driven while asleep");
    a_oe_cause: assert property ($rose(sramDataOe) |-> $past(sramSelect || addressAdvance)
        || $past(sramSelect || addressAdvance, 2)) else $error("data driven without a read");
    a_flow_lat: assert property (rdLoad && !mode_reg |=> sramDataOe) else $error("flow read late");
    a_reg_lat: assert property (rdLoad && mode_reg |=> ##1 sramDataOe) else $error("registered read late");
    a_refuse_hold: assert property (writeRefused && !(busReq && wb_we_i && wb_adr_i == 4'h4)
        |=> writeRefused) else $error("refusal flag lost");
    a_refuse_why: assert property ($rose(writeRefused) |-> $past(sramSelect && writeEnable || addressAdvance, 2))
        else $error("refusal without a write");
endmodule
bind sbs_sram_ctrl sbs_sram_ctrl_props sbs_sram_ctrl_props_inst (.mclk, .reset_n, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_ack_o, .wb_adr_i, .wb_sel_i, .wb_dat_i, .sramSelect, .writeEnable, .addressAdvance,
    .sleepRequest, .sramDataOe, .writeRefused);

// ===== test/sbs_mem_master.sv
// Memory controller model driving the core's command pins
`timescale 1ns/10ps
module sbs_mem_master (
    // Clock
    input  wire        mclk,
    // Command pins
    output reg         sramSelect,
    output reg         writeEnable,
    output reg         addressAdvance,
    output reg  [7:0]  sramAddr,
    output reg  [15:0] sramDataIn,
    output reg         sleepRequest
);
    initial begin
        {sramSelect, writeEnable, addressAdvance, sramAddr, sramDataIn} = 27'h0;
        sleepRequest = 1'b0;
    end
    // One load cycle, then n continue cycles; released lines show a changing pattern
    task cmd(input bit we, input [7:0] a, input [15:0] d, input int n);
        @(posedge mclk);
        {sramSelect, writeEnable, addressAdvance, sramAddr, sramDataIn} <= {1'b1, we, 1'b0, a, d};
        repeat (n) begin
            @(posedge mclk);
            {sramSelect, addressAdvance, sramAddr, sramDataIn} <= {2'b01, ~sramAddr, ~sramDataIn};
        end
        @(posedge mclk);
        {sramSelect, writeEnable, addressAdvance, sramAddr, sramDataIn} <= {3'b000, ~a, ~d};
    endtask
    // Only called once every access has finished
    task doze(input int n);
        @(posedge mclk);
        sleepRequest <= 1'b1;
        repeat (n) @(posedge mclk);
        sleepRequest <= 1'b0;
    endtask
endmodule

// ===== test/sbs_sram_burst_order_and_sleep_test.sv
// Self-checking bench for the burst SRAM core
`timescale 1ns/10ps
`include "sbs_map.vh"
`define CHK(n, e, a) begin checksDone++; if ((a) !== (e)) begin errorCnt++; $display("ERROR %s exp %h seen %h", n, e, a); end end
module sbs_sram_burst_order_and_sleep_test;
    reg         mclk = 1'b0, reset_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    reg  [3:0]  adr = 4'h0;
    reg  [31:0] wdat = 32'h0, rv;
    wire [31:0] rdat;
    wire        ack, sel, wen, address_advance, zz, oe, wRef;
    wire [7:0]  addr;
    wire [15:0] mData, dOut;
    wire [15:0] dq = oe ? dOut : mData;
    int         errorCnt = 0, checksDone = 0;
    logic [15:0] q[$];
    sbs_sram_ctrl #(.AW(8), .DW(16)) sbs_sram_ctrl_inst (.mclk(mclk), .reset_n(reset_n), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .sramSelect(sel), .writeEnable(wen), .addressAdvance(address_advance), .sramAddr(addr),
        .sramDataIn(dq), .sleepRequest(zz), .sramDataOut(dOut), .sramDataOe(oe), .writeRefused(wRef));
    sbs_mem_master sbs_mem_master_inst (.mclk(mclk), .sramSelect(sel), .writeEnable(wen),
        .addressAdvance(address_advance), .sramAddr(addr), .sramDataIn(mData), .sleepRequest(zz));
    initial forever #12.5 mclk = ~mclk;
    always @(posedge mclk) if (oe === 1'b1) q.push_back(dOut);
    ////////////////////////////////////////////////////////////////////////////////
    task tallyAndFinish();
        $display("Checks %0d, errors %0d", checksDone, errorCnt);
        if (errorCnt == 0 && checksDone > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task wb(input bit w, input [3:0] a, input [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        do begin
            @(posedge mclk);
            n = n + 1;
        end while (ack !== 1'b1 && n < 20);
        rv = rdat;
        if (ack !== 1'b1) errorCnt++;
        {cyc, stb, we} <= 3'b000;
    endtask
    task rd(input [3:0] a, input [31:0] e);
        wb(1'b0, a, 32'h0);
        `CHK("register", e, rv)
    endtask
    task mc(input bit w, input [7:0] a, input [15:0] d, input int n);
        sbs_mem_master_inst.cmd(w, a, d, n);
    endtask
    task waitBeats(input int n);
        int t;
        t = 0;
        while (q.size() < n && t < 10) begin
            @(posedge mclk);
            t = t + 1;
        end
        `CHK("beats", n, q.size())
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Fill four words, then read a five-beat burst from every start offset
    task burst(input [1:0] mode);
        logic [1:0] lo;
        wb(1'b1, `SBS_WB_OFS_CTRL, {30'h0, mode});
        for (int j = 0; j < 4; j++) mc(1'b1, 8'h40 | 8'(j), {mode, 8'hA8, 6'(j)}, 0);
        for (int s = 0; s < 4; s++) begin
            q.delete();
            mc(1'b0, 8'h40 | 8'(s), 16'h0000, 4);
            waitBeats(5);
            for (int k = 0; k < 5; k++) begin
                lo = mode[1] ? 2'(s) ^ 2'(k) : 2'(s + k);
                `CHK("beat", ({mode, 8'hA8, 4'h0, lo}), q[k])
            end
        end
    endtask
    // Keep a word across sleep, refuse a write while recovering, clear the flag
    task sleepTest();
        wb(1'b1, `SBS_WB_OFS_RECOV, 32'h20);
        rd(`SBS_WB_OFS_RECOV, 32'h20);
        mc(1'b1, 8'h77, 16'hBEEF, 0);
        fork
            sbs_mem_master_inst.doze(30);
            begin
                repeat (8) @(posedge mclk);
                q.delete();
                mc(1'b0, 8'h77, 16'h0000, 0);
                rd(`SBS_WB_OFS_STAT, 32'h1);
                `CHK("float", 0, q.size())
            end
        join
        repeat (4) @(posedge mclk);
        rd(`SBS_WB_OFS_STAT, 32'h2);
        mc(1'b1, 8'h77, 16'h1234, 0);
        rd(`SBS_WB_OFS_STAT, 32'h6);
        `CHK("refused", 1'b1, wRef)
        repeat (40) @(posedge mclk);
        rd(`SBS_WB_OFS_STAT, 32'h4);
        wb(1'b1, `SBS_WB_OFS_STAT, 32'h0);
        rd(`SBS_WB_OFS_STAT, 32'h0);
        `CHK("refused", 1'b0, wRef)
        q.delete();
        mc(1'b0, 8'h77, 16'h0000, 0);
        waitBeats(1);
        `CHK("kept", 16'hBEEF, q[0])
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge mclk);
        reset_n <= 1'b1;
        rd(`SBS_WB_OFS_CTRL, {30'h0, `SBS_CTRL_RESET});
        rd(`SBS_WB_OFS_STAT, 32'h0);
        rd(`SBS_WB_OFS_RECOV, 32'h1);
        wb(1'b1, 4'hC, 32'hFFFF_FFFF);
        rd(4'hC, 32'h0);
        rd(`SBS_WB_OFS_CTRL, 32'h1);
        for (int m = 0; m < 4; m++) burst(2'(m));
        sleepTest();
        tallyAndFinish();
    end
    initial begin
        #(25 * 20000);
        errorCnt++;
        tallyAndFinish();
    end
endmodule
